// [adcc_pkg.sv]
// package of constants and types for the converter control block
package adcc_pkg;
  localparam int ADCC_RES_W = 12;
  localparam int ADCC_NCH = 8;
  localparam int ADCC_AW = 2;
  localparam logic [1:0] ADCC_OFF_RESULT_LOW = 2'h0;
  localparam logic [1:0] ADCC_OFF_RESULT_HIGH = 2'h1;
  localparam logic [1:0] ADCC_OFF_CONTROL = 2'h2;
  localparam logic [1:0] ADCC_OFF_PIN_SELECT = 2'h3;
  localparam int ADCC_START_BIT = 7;
  localparam int ADCC_BUSY_BIT = 6;
  localparam int ADCC_CHSEL_LSB = 0;
  localparam int ADCC_LOW_RES_LSB = 4;
  localparam logic ADCC_START_RST = 1'b0;
  localparam logic ADCC_BUSY_RST = 1'b1;
  localparam logic [2:0] ADCC_CHSEL_RST = 3'h0;
  localparam logic [7:0] ADCC_PINSEL_RST = 8'h00;
  localparam logic [11:0] ADCC_RESULT_RST = 12'h000;
  localparam int ADCC_CLK_NS = 100;
  localparam int ADCC_BIT_NS = 500;
  localparam int ADCC_BIT_CYC_I = (ADCC_BIT_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS;
  localparam logic [3:0] ADCC_BIT_CYC = 4'(ADCC_BIT_CYC_I);
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_HOLD = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_e;
endpackage

// [adcc_sar.sv]
// successive approximation sequencer driving an external comparator
`timescale 1ns/100ps
module adcc_sar (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic go,
  input wire logic cmp_high,
  output logic [adcc_pkg::ADCC_RES_W-1:0] dac_code,
  output logic done,
  output logic [adcc_pkg::ADCC_RES_W-1:0] result
);
  import adcc_pkg::*;
  typedef struct packed {
    logic run;
    logic [3:0] bitn;
    logic [3:0] tick;
    logic [ADCC_RES_W-1:0] trial;
    logic [ADCC_RES_W-1:0] res;
    logic done;
  } adcc_sar_s;
  adcc_sar_s st;
  adcc_sar_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (clear) begin
      next_st.run = 1'b0;
      next_st.trial = '0;
    end else if (go && !st.run && !st.done) begin
      // no relaunch in the cycle the finished word is handed over
      next_st.run = 1'b1;
      next_st.bitn = 4'(ADCC_RES_W - 1);
      next_st.tick = ADCC_BIT_CYC;
      next_st.trial = 12'h800;
    end else if (st.run) begin
      // settle time per trial bit before the comparator is trusted
      if (st.tick != 4'h1) begin
        next_st.tick = st.tick - 4'h1;
      end else begin
        next_st.tick = ADCC_BIT_CYC;
        if (!cmp_high) begin
          next_st.trial[st.bitn] = 1'b0;
        end
        if (st.bitn == 4'h0) begin
          next_st.run = 1'b0;
          next_st.done = 1'b1;
          next_st.res = cmp_high ? st.trial : (st.trial & ~12'h001);
        end else begin
          next_st.bitn = st.bitn - 4'h1;
          next_st.trial[st.bitn - 4'h1] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dac_code = st.trial;
  assign done = st.done;
  assign result = st.res;
endmodule

// [adcc_pin.sv]
// one shared port pin: analog mode gates pull-high and direction
`timescale 1ns/100ps
module adcc_pin (
  input wire logic analog_en,
  input wire logic port_dir_in,
  input wire logic port_pull_en,
  output logic pin_oe,
  output logic pin_pull_en
);
  // analog pin never driven, pull disconnected
  assign pin_oe = !analog_en && !port_dir_in;
  assign pin_pull_en = !analog_en && port_pull_en;
endmodule

// [adcc_top.sv]
// register file and conversion control of the converter block
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
// Functional notes
// - one 12-bit converter fed by an eight-input multiplexer
// - high result byte holds result bits 11 to 4
// - low result byte holds bits 3 to 0 in top nibble, low nibble zero
// - result bytes read-only, hold last completed conversion
// - three-bit channel select routes input n to converter
// - start bit raised then lowered begins a conversion
// - while start bit high, converter held reset and busy forced one
// - busy flag read-only, one during conversion, zero after
// - control bits 5 to 3 unimplemented, read zero
// - pin select bit n makes port pin n analog input
// - busy flag cleared by hardware when conversion completes
// - end of conversion raises the converter interrupt request pulse
// - analog pin loses pull-high and direction control
module adcc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [adcc_pkg::ADCC_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic cmp_high,
  output logic [adcc_pkg::ADCC_RES_W-1:0] dac_code,
  output logic [2:0] channel_select,
  output logic [adcc_pkg::ADCC_NCH-1:0] pin_analog_enables,
  output logic conv_reset,
  output logic conv_irq,
  input wire logic [adcc_pkg::ADCC_NCH-1:0] port_dir_in,
  input wire logic [adcc_pkg::ADCC_NCH-1:0] port_pull_en,
  output logic [adcc_pkg::ADCC_NCH-1:0] port_a_pins_oe,
  output logic [adcc_pkg::ADCC_NCH-1:0] port_a_pins_pull
);
  import adcc_pkg::*;
  typedef struct packed {
    adcc_state_e state;
    logic start;
    logic busy;
    logic [2:0] chsel;
    logic [7:0] pinsel;
    logic [ADCC_RES_W-1:0] result;
    logic [7:0] rdata;
    logic irq;
  } adcc_top_s;
  adcc_top_s st;
  adcc_top_s next_st;
  logic sar_done;
  logic [ADCC_RES_W-1:0] sar_result;
  logic sar_go;
  logic sar_clear;
  logic [7:0] ctrl_view;
  logic [7:0] high_view;
  logic [7:0] low_view;

  // bits 5..3 are tied zero on read
  assign ctrl_view = {st.start, st.busy, 3'h0, st.chsel};
  assign high_view = st.result[ADCC_RES_W-1:ADCC_LOW_RES_LSB];
  assign low_view = {st.result[ADCC_LOW_RES_LSB-1:0], 4'h0};

  always_comb begin
    next_st = st;
    next_st.irq = 1'b0;
    if (wr) begin
      case (addr)
        ADCC_OFF_CONTROL: begin
          next_st.start = wdata[ADCC_START_BIT];
          next_st.chsel = wdata[ADCC_CHSEL_LSB +: 3];
        end
        ADCC_OFF_PIN_SELECT: begin
          next_st.pinsel = wdata;
        end
        default: begin
          // result bytes ignore writes
        end
      endcase
    end
    case (st.state)
      ADCC_IDLE: begin
        if (next_st.start) begin
          next_st.state = ADCC_HOLD;
          next_st.busy = 1'b1;
        end
      end
      ADCC_HOLD: begin
        next_st.busy = 1'b1;
        if (!next_st.start) begin
          next_st.state = ADCC_CONV;
        end
      end
      ADCC_CONV: begin
        if (next_st.start) begin
          // raising start again aborts and restarts the cycle
          next_st.state = ADCC_HOLD;
        end else if (sar_done) begin
          next_st.state = ADCC_IDLE;
          next_st.busy = 1'b0;
          next_st.result = sar_result;
          next_st.irq = 1'b1;
        end
      end
      default: begin
        next_st.state = ADCC_IDLE;
      end
    endcase
    next_st.rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADCC_OFF_RESULT_LOW: next_st.rdata = low_view;
        ADCC_OFF_RESULT_HIGH: next_st.rdata = high_view;
        ADCC_OFF_CONTROL: next_st.rdata = ctrl_view;
        ADCC_OFF_PIN_SELECT: next_st.rdata = st.pinsel;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.state <= ADCC_IDLE;
      st.start <= ADCC_START_RST;
      st.busy <= ADCC_BUSY_RST;
      st.chsel <= ADCC_CHSEL_RST;
      st.pinsel <= ADCC_PINSEL_RST;
      st.result <= ADCC_RESULT_RST;
      st.rdata <= 8'h00;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // converter held in reset except during an active cycle
  assign sar_clear = st.state != ADCC_CONV;
  assign sar_go = st.state == ADCC_CONV;

  adcc_sar u_sar (
    .mclk(mclk),
    .rst(rst),
    .clear(sar_clear),
    .go(sar_go),
    .cmp_high(cmp_high),
    .dac_code(dac_code),
    .done(sar_done),
    .result(sar_result)
  );

  genvar gi;
  generate
    for (gi = 0; gi < ADCC_NCH; gi++) begin : g_pin
      adcc_pin u_pin (
        .analog_en(st.pinsel[gi]),
        .port_dir_in(port_dir_in[gi]),
        .port_pull_en(port_pull_en[gi]),
        .pin_oe(port_a_pins_oe[gi]),
        .pin_pull_en(port_a_pins_pull[gi])
      );
    end
  endgenerate

  assign rdata = st.rdata;
  assign channel_select = st.chsel;
  assign pin_analog_enables = st.pinsel;
  assign conv_reset = sar_clear;
  assign conv_irq = st.irq;
endmodule

// [adcc_ain_model.sv]
// comparator behind the analog mux, far side of the converter
`timescale 1ns/100ps
module adcc_ain_model (
  input wire logic [2:0] channel_select,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] lvl [8],
  output logic cmp_high
);
  // ideal comparator: no offset, settles at once
  assign cmp_high = lvl[channel_select] >= dac_code;
endmodule

// [adcc_top_sva.sv]
// port assertions for the converter control block
`timescale 1ns/100ps
module adcc_top_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic conv_reset,
  input wire logic conv_irq,
  input wire logic [7:0] pin_analog_enables,
  input wire logic [7:0] port_dir_in,
  input wire logic [7:0] port_a_pins_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_irq_pulse: assert property (conv_irq |=> !conv_irq)
    else $error("irq longer than one cycle");
  chk_irq_cause: assert property (conv_irq |-> !$past(conv_reset))
    else $error("irq without conversion");
  chk_conv_end: assert property ($fell(conv_reset) |-> ##[1:70] (conv_irq || conv_reset))
    else $error("conversion did not end");
  chk_hold_reset: assert property (wr && addr == 2'h2 && wdata[7] |=> conv_reset)
    else $error("converter not held");
  chk_low_zero: assert property (rd && addr == 2'h0 |=> rdata[3:0] == 4'h0)
    else $error("low nibble not zero");
  chk_ctrl_zero: assert property (rd && addr == 2'h2 |=> rdata[5:3] == 3'h0)
    else $error("unused control bits set");
  chk_pin_map: assert property (wr && addr == 2'h3 |=> pin_analog_enables == $past(wdata))
    else $error("pin select not taken");
  chk_oe_gate: assert property (port_a_pins_oe == (~pin_analog_enables & ~port_dir_in))
    else $error("analog pin still driven");
endmodule
bind adcc_top adcc_top_chk i_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .conv_reset(conv_reset), .conv_irq(conv_irq),
  .pin_analog_enables(pin_analog_enables), .port_dir_in(port_dir_in),
  .port_a_pins_oe(port_a_pins_oe));

// [adcc_top_bench.sv]
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adcc_top_bench;
  logic mclk = 0, rst = 1, wr = 0, rd = 0, cmp_high, conv_reset, conv_irq;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, rdata, v, oe, pull_o, pae, dir = 8'h0F, pull = 8'hFF;
  logic [11:0] dac_code, lvl [8];
  logic [2:0] chs;
  logic [7:0] pv [3] = '{8'hFF, 8'h00, 8'hA5};
  int mismatches = 0, total_checks = 0, cycles = 0, irqs = 0;
  initial forever #50 mclk = ~mclk;
  adcc_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmp_high(cmp_high), .dac_code(dac_code), .channel_select(chs),
    .pin_analog_enables(pae), .conv_reset(conv_reset), .conv_irq(conv_irq),
    .port_dir_in(dir), .port_pull_en(pull), .port_a_pins_oe(oe), .port_a_pins_pull(pull_o));
  adcc_ain_model i_ain (.channel_select(chs), .dac_code(dac_code), .lvl(lvl),
    .cmp_high(cmp_high));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(logic [1:0] a, logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [1:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // start written low only: no pulse, so busy must stay at its reset one
  task automatic t_control;
    rd_reg(2'h2);
    chk("control", v, 8'h40);
    for (int c = 0; c < 8; c++) begin
      wr_reg(2'h2, 8'h38 | 8'(c));
      rd_reg(2'h2);
      chk("control", v, 8'h40 | 8'(c));
      chk("channel", 8'(chs), 8'(c));
    end
  endtask
  task automatic t_pins;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      dir <= pv[i] ^ 8'h3C;
      pull <= pv[i] ^ 8'h5A;
      wr_reg(2'h3, pv[i]);
      rd_reg(2'h3);
      chk("pin select", v, pv[i]);
      chk("pin enables", pae, pv[i]);
      chk("pin pull", pull_o, ~pv[i] & pull);
      chk("pin drive", oe, ~pv[i] & ~dir);
    end
  endtask
  task automatic t_conv(logic [2:0] c, logic [11:0] x);
    int n;
    int k;
    lvl[c] = x;
    k = irqs;
    wr_reg(2'h2, 8'h80 | 8'(c));
    rd_reg(2'h2);
    chk("held control", v, 8'hC0 | 8'(c));
    chk("held reset", 8'(conv_reset), 8'h01);
    chk("held code", 8'(dac_code == 12'h000), 8'h01);
    wr_reg(2'h2, 8'(c));
    n = 0;
    v = 8'h40;
    while (v[6] && n < 100) begin
      rd_reg(2'h2);
      n++;
      if (n == 1) chk("run reset", 8'(conv_reset), 8'h00);
    end
    chk("busy", 8'(v[6]), 8'h00);
    // twelve trials of five cycles each, two cycles per poll
    chk("long enough", 8'(n >= 30), 8'h01);
    chk("irq count", 8'(irqs - k), 8'h01);
    wr_reg(2'h1, 8'h00);
    rd_reg(2'h1);
    chk("result high", v, x[11:4]);
    wr_reg(2'h0, 8'hFF);
    rd_reg(2'h0);
    chk("result low", v, {x[3:0], 4'h0});
  endtask
  // start raised again mid-conversion: converter back in reset, busy held
  task automatic t_abort;
    wr_reg(2'h2, 8'h85);
    wr_reg(2'h2, 8'h05);
    rd_reg(2'h2);
    chk("run control", v, 8'h45);
    wr_reg(2'h2, 8'h85);
    rd_reg(2'h2);
    chk("abort control", v, 8'hC5);
    chk("abort reset", 8'(conv_reset), 8'h01);
    wr_reg(2'h2, 8'h05);
  endtask
  initial begin
    for (int i = 0; i < 8; i++) lvl[i] = 12'h000;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_control;
    t_pins;
    t_conv(3'h7, 12'hFFF);
    t_conv(3'h0, 12'h000);
    t_abort;
    t_conv(3'h3, 12'h5A3);
    test_done;
  end
  always @(posedge mclk) begin
    cycles++;
    if (conv_irq === 1'b1) irqs++;
    if (cycles == 5000) begin
      mismatches++;
      test_done;
    end
  end
endmodule
